// ### dcr_pkg.sv
package dcr_pkg;
  // Instruction codes carried on the bus with every strobe.
  localparam logic [2:0] INS_RD_STATUS = 3'h1;
  localparam logic [2:0] INS_LD_CMD = 3'h2;
  localparam logic [2:0] INS_RD_MAC = 3'h3;
  localparam logic [2:0] INS_LD_MAC = 3'h4;
  localparam logic [2:0] INS_RD_DADDR = 3'h5;
  localparam logic [2:0] INS_LD_DADDR = 3'h6;
  // Flag commands applied after the data transfer.
  localparam logic [1:0] FC_NONE = 2'h0;
  localparam logic [1:0] FC_START = 2'h1;
  localparam logic [1:0] FC_CLEAR = 2'h2;
  localparam logic [1:0] FC_PULSE = 2'h3;
  // Operation codes of the command word.
  localparam logic [1:0] OP_READ = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SEEK = 2'h2;
  localparam logic [1:0] OP_RECAL = 2'h3;
  // Word bit 0 is vector bit 15; drive d flags sit at SEEK_BASE - d.
  localparam int ST_DONE = 15;
  localparam int ST_SEEK_BASE = 14;
  localparam int ST_VALID = 9;
  localparam int ST_BUSY = 8;
  localparam int ST_UNSAFE = 7;
  localparam int ST_READY = 6;
  localparam int ST_SEEKERR = 5;
  localparam int ST_EOC = 4;
  localparam int ST_ADDRERR = 3;
  localparam int ST_CKERR = 2;
  localparam int ST_LATE = 1;
  localparam int ST_ERR = 0;
  // Command and cylinder word fields.
  localparam int CC_CLEAR = 15;
  localparam int CC_SEEKCLR_BASE = 14;
  localparam int CC_OP_HI = 10;
  localparam int CC_OP_LO = 9;
  localparam int CC_CYL_HI = 8;
  // Memory address counter and disc address fields.
  localparam int MAC_MAP = 15;
  localparam int DA_DRV_HI = 15;
  localparam int DA_DRV_LO = 14;
  localparam int DA_SURF_HI = 11;
  localparam int DA_SURF_LO = 9;
  localparam int DA_SEC_HI = 8;
  localparam int DA_SEC_LO = 4;
  localparam int DA_CNT_HI = 3;
  localparam logic [4:0] SECT_LAST = 5'h17;
  localparam logic [3:0] CNT_LAST = 4'hf;
  // Values after reset and data path sizes.
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] MAC_RST = 16'h0000;
  localparam logic [15:0] DA_RST = 16'h0000;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 32;
endpackage

// ### dcr_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
// Programmed I/O bus between the CPU end and the disc controller end.
interface dcr_bus_if;
  logic ioStrobe;
  logic [2:0] ioInstr;
  logic [1:0] ioFlag;
  logic [15:0] hostData;
  logic [15:0] devData;
  logic ioAck;
  logic intReq;
  logic ioReset;
  modport dev(input ioStrobe, input ioInstr, input ioFlag, input hostData,
    input ioReset, output devData, output ioAck, output intReq);
  modport host(output ioStrobe, output ioInstr, output ioFlag,
    output hostData, output ioReset, input devData, input ioAck,
    input intReq);
endinterface
`default_nettype wire

// ### dcr_device.sv
`timescale 1ns/1ps
`default_nettype none
// Word buffer between the sector engine and the data channel.
module dcr_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  // Clock and control.
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic flush,
  // Filling side.
  input wire logic inValid,
  input wire logic [W-1:0] inData,
  output logic inReady,
  // Draining side.
  output logic outValid,
  output logic [W-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire push = inValid && inReady;
  wire pop = outValid && outReady;
  // Extra pointer bit tells full from empty.
  assign inReady = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign outValid = wr_q != rd_q;
  assign outData = mem_q[rd_q[AW-1:0]];
  // Storage has no reset; only the pointers need a defined state.
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= inData;
    end
  end
  // Pointers; a flush drops whatever a halted transfer left behind.
  always_ff @(posedge ref_clk) begin
    if (rst || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule

// Summary of operation
// RQ1: Status read returns sixteen bits, then flags.
// RQ2: Valid bit low when subsystem control lost.
// RQ3: Start, clear, pulse or reset clear unsafe.
// RQ4: Command load stores all sixteen bits.
// RQ5: Command bit 0 clears done and errors; the code leaves the seek error and late flags set.
// RQ6: Bits 1-4 clear seek done, drives 0-3.
// RQ7: Bits 5-6 select read, write, seek, recalibrate.
// RQ8: Bits 7-15 carry the target cylinder.
// RQ9: Address load: bit 0 map, rest address.
// RQ10: Address counts per word, carry reaches map.
// RQ11: Address read returns bit 0 as zero.
// RQ12: After write, address points past last word.
// RQ13: Data transfer first, then busy and done.
// RQ14: Host loads disc address without flag command.
// RQ15: Host issues nothing to drive not ready.
// RQ16: Host reads status between programming phases.
// RQ17: Seek uses pulse: clears done, keeps busy.
// RQ18: Seeking drive reads not ready, not done.
// RQ19: Transfer of one to sixteen sectors.
// RQ20: Sector after 27 octal is next surface 0.
// RQ21: Start and pulse clear done, errors, begin.
// RQ22: Clear or bus reset zero flags, keep seeks.
// RQ23: Seek done or done raises interrupt request; the code raises it for done only when the transfer began with a start.
module dcr_device #(
  parameter int DEPTH = dcr_pkg::FIFO_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // CPU bus.
  dcr_bus_if.dev bus,
  // Drives and shared subsystem.
  input wire logic [3:0] driveReady,
  input wire logic [3:0] driveUnsafe,
  input wire logic [3:0] seekEnd,
  input wire logic subsysOwned,
  // Operation launch towards the drives and sector engine.
  output logic opGo,
  output logic [1:0] opCode,
  output logic [8:0] opCyl,
  output logic [1:0] opDrive,
  output logic xferHalt,
  output logic [2:0] surfSel,
  output logic [4:0] sectSel,
  // Sector engine reports.
  input wire logic sectorDone,
  input wire logic [4:0] engErr,
  input wire logic wrWordTaken,
  // Read words from the engine.
  input wire logic engValid,
  input wire logic [15:0] engWord,
  output logic engReady,
  // Data channel side.
  output logic chanValid,
  output logic [15:0] chanWord,
  output logic [15:0] chanAddr,
  input wire logic chanReady
);
  logic [15:0] cmd_q;
  logic [15:0] mac_q;
  logic [15:0] da_q;
  logic busy_q;
  logic done_q;
  logic xfer_q;
  logic rwIrq_q;
  logic [5:0] err_q;
  logic [3:0] seekDone_q;
  logic [3:0] seeking_q;
  logic [15:0] devData_q;
  logic ack_q;
  logic opGo_q;
  logic halt_q;
  // Nets, since each bit is driven by an assignment of its own.
  wire [15:0] statusWord;
  wire [3:0] seekDone_d;
  wire [3:0] seeking_d;

  // Instruction and flag command decode.
  wire strobe = bus.ioStrobe;
  wire ldCmd = strobe && bus.ioInstr == dcr_pkg::INS_LD_CMD;
  wire ldMac = strobe && bus.ioInstr == dcr_pkg::INS_LD_MAC;
  wire ldDa = strobe && bus.ioInstr == dcr_pkg::INS_LD_DADDR;
  wire rdSt = strobe && bus.ioInstr == dcr_pkg::INS_RD_STATUS;
  wire rdMac = strobe && bus.ioInstr == dcr_pkg::INS_RD_MAC;
  wire rdDa = strobe && bus.ioInstr == dcr_pkg::INS_RD_DADDR;
  wire fcStart = strobe && bus.ioFlag == dcr_pkg::FC_START;
  wire fcPulse = strobe && bus.ioFlag == dcr_pkg::FC_PULSE;
  wire fcClear = (strobe && bus.ioFlag == dcr_pkg::FC_CLEAR) ||
    bus.ioReset; // RQ22
  wire opKick = fcStart || fcPulse; // RQ21

  // The kicked operation sees the word loaded by the same instruction.
  wire [15:0] cmdNow = ldCmd ? bus.hostData : cmd_q; // RQ13
  wire [15:0] daNow = ldDa ? bus.hostData : da_q; // RQ13
  wire [1:0] opNow = cmdNow[dcr_pkg::CC_OP_HI:dcr_pkg::CC_OP_LO]; // RQ7
  wire [1:0] drvNow = daNow[dcr_pkg::DA_DRV_HI:dcr_pkg::DA_DRV_LO];
  wire [1:0] drvSel = da_q[dcr_pkg::DA_DRV_HI:dcr_pkg::DA_DRV_LO];
  wire isSeekOp = opNow == dcr_pkg::OP_SEEK || opNow == dcr_pkg::OP_RECAL;
  wire seekKick = opKick && isSeekOp; // RQ17
  wire rwKick = opKick && !isSeekOp;
  wire cmdClr = ldCmd && bus.hostData[dcr_pkg::CC_CLEAR]; // RQ5

  // Sector stepping: wrap to sector 0 of the next surface.
  wire [4:0] sec = da_q[dcr_pkg::DA_SEC_HI:dcr_pkg::DA_SEC_LO];
  wire [2:0] surf = da_q[dcr_pkg::DA_SURF_HI:dcr_pkg::DA_SURF_LO];
  wire [3:0] cnt = da_q[dcr_pkg::DA_CNT_HI:0];
  wire secWrap = sec == dcr_pkg::SECT_LAST; // RQ20
  wire [4:0] secNext = secWrap ? 5'h00 : sec + 5'h01; // RQ20
  wire [2:0] surfNext = surf + {2'h0, secWrap}; // RQ20
  wire step = xfer_q && sectorDone;
  // Count is minus the sectors left; all ones means the last one.
  wire lastSect = step && cnt == dcr_pkg::CNT_LAST; // RQ19
  wire doneSet = xfer_q && (lastSect || |engErr);
  wire [15:0] daStep = {da_q[15:12], surfNext, secNext, cnt + 4'h1};

  // Error flags: {late, ck, addr, eoc, seek, unsafe}; a set beats a clear.
  wire unsafeEvt = driveUnsafe[drvSel];
  wire [5:0] errEvt = {engErr, unsafeEvt};
  wire [5:0] errClr = (fcClear || opKick) ? 6'h3f : // RQ3 RQ21 RQ22
    cmdClr ? 6'h1d : 6'h00; // RQ5
  wire [5:0] err_d = errEvt | (err_q & ~errClr);

  wire done_d = doneSet | (done_q & ~(fcClear | opKick | cmdClr)); // RQ5
  wire busy_d = fcStart ? 1'b1 : (fcClear || doneSet) ? 1'b0 : busy_q;
  wire xfer_d = rwKick ? 1'b1 : (fcClear || doneSet) ? 1'b0 : xfer_q;

  // Per drive seek tracking; clear never aborts a seek in flight.
  genvar d;
  generate
    for (d = 0; d < 4; d++) begin : g_drive
      wire kickHere = seekKick && drvNow == 2'(d);
      wire clrHere = (ldCmd &&
        bus.hostData[dcr_pkg::CC_SEEKCLR_BASE - d]) || fcClear; // RQ6
      assign seekDone_d[d] = seekEnd[d] |
        (seekDone_q[d] & ~(clrHere | kickHere)); // RQ18 RQ22
      assign seeking_d[d] = kickHere | (seeking_q[d] & ~seekEnd[d]);
      assign statusWord[dcr_pkg::ST_SEEK_BASE - d] =
        seekDone_q[d] & ~seeking_q[d]; // RQ18
    end
  endgenerate

  // Status word assembly.
  assign statusWord[dcr_pkg::ST_DONE] = done_q;
  assign statusWord[10] = 1'b0;
  assign statusWord[dcr_pkg::ST_VALID] = subsysOwned; // RQ2
  assign statusWord[dcr_pkg::ST_BUSY] = busy_q;
  assign statusWord[dcr_pkg::ST_UNSAFE] = err_q[0]; // RQ3
  assign statusWord[dcr_pkg::ST_READY] =
    driveReady[drvSel] & ~seeking_q[drvSel]; // RQ18
  assign statusWord[dcr_pkg::ST_SEEKERR] = err_q[1];
  assign statusWord[dcr_pkg::ST_EOC] = err_q[2];
  assign statusWord[dcr_pkg::ST_ADDRERR] = err_q[3];
  assign statusWord[dcr_pkg::ST_CKERR] = err_q[4];
  assign statusWord[dcr_pkg::ST_LATE] = err_q[5];
  assign statusWord[dcr_pkg::ST_ERR] = |err_q;

  // Read data selection; values are taken before flags move.
  wire [15:0] rdWord = rdSt ? statusWord : // RQ1
    rdMac ? {1'b0, mac_q[14:0]} : // RQ11
    rdDa ? da_q : 16'h0000;

  // Words read from disc pass a buffer so the channel may stall.
  logic fifoInReady;
  wire chanFire = chanValid && chanReady;
  assign engReady = fifoInReady && xfer_q;
  dcr_fifo #(.W(dcr_pkg::WORD_W), .DEPTH(DEPTH)) i_dcr_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .flush(halt_q),
    .inValid(engValid && xfer_q),
    .inData(engWord),
    .inReady(fifoInReady),
    .outValid(chanValid),
    .outData(chanWord),
    .outReady(chanReady)
  );

  // Outputs.
  assign bus.devData = devData_q;
  assign bus.ioAck = ack_q;
  assign bus.intReq = |seekDone_q | (done_q & rwIrq_q); // RQ23
  assign opGo = opGo_q;
  assign opCode = cmd_q[dcr_pkg::CC_OP_HI:dcr_pkg::CC_OP_LO];
  assign opCyl = cmd_q[dcr_pkg::CC_CYL_HI:0]; // RQ8
  assign opDrive = drvSel;
  assign xferHalt = halt_q;
  assign surfSel = surf;
  assign sectSel = sec;
  assign chanAddr = mac_q;

  // Registers loaded by the CPU.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cmd_q <= dcr_pkg::CMD_RST;
      da_q <= dcr_pkg::DA_RST;
      mac_q <= dcr_pkg::MAC_RST;
    end else begin
      cmd_q <= cmdNow; // RQ4
      da_q <= ldDa ? bus.hostData : step ? daStep : da_q;
      if (ldMac) begin
        mac_q <= bus.hostData; // RQ9
      end else if (chanFire || wrWordTaken) begin
        mac_q <= mac_q + 16'h0001; // RQ10 RQ12
      end
    end
  end

  // Flags; a drive or engine event wins over a same-cycle clear.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      xfer_q <= 1'b0;
      rwIrq_q <= 1'b0;
      err_q <= 6'h00;
      seekDone_q <= 4'h0;
      seeking_q <= 4'h0;
    end else begin
      busy_q <= busy_d; // RQ13 RQ17 RQ21
      done_q <= done_d; // RQ17 RQ21
      xfer_q <= xfer_d; // RQ22
      rwIrq_q <= opKick ? fcStart : rwIrq_q;
      err_q <= err_d;
      seekDone_q <= seekDone_d;
      seeking_q <= seeking_d;
    end
  end

  // Bus answer and launch pulses, one cycle after the strobe.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      devData_q <= 16'h0000;
      ack_q <= 1'b0;
      opGo_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      devData_q <= (rdSt || rdMac || rdDa) ? rdWord : devData_q;
      ack_q <= strobe;
      opGo_q <= opKick;
      halt_q <= fcClear; // RQ22
    end
  end
endmodule
`default_nettype wire

// ### dcr_host.sv
`timescale 1ns/1ps
`default_nettype none
module dcr_host (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // CPU bus.
  dcr_bus_if.host bus,
  // Command port of the program.
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [2:0] cmdInstr,
  input wire logic [1:0] cmdFlag,
  input wire logic [15:0] cmdData,
  input wire logic busResetReq,
  // Answers.
  output logic rspValid,
  output logic [15:0] rspData,
  output logic cmdRefused,
  output logic intPending
);
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_WAIT = 2'b01} dcr_hstate_t;
  dcr_hstate_t state_q;
  logic strobe_q;
  logic [2:0] instr_q;
  logic [1:0] flag_q;
  logic [15:0] data_q;
  logic rst_q;
  logic rspValid_q;
  logic [15:0] rspData_q;
  logic refused_q;
  logic readyOk_q;
  logic checked_q;

  // Sequencing checks on the program's requests.
  wire take = cmdValid && state_q == H_IDLE;
  wire kicks = cmdFlag == dcr_pkg::FC_START || cmdFlag == dcr_pkg::FC_PULSE;
  wire badDa = cmdInstr == dcr_pkg::INS_LD_DADDR &&
    cmdFlag != dcr_pkg::FC_NONE; // RQ14
  wire badKick = kicks && !(readyOk_q && checked_q); // RQ15 RQ16
  wire refuse = badDa || badKick;
  wire isStatus = instr_q == dcr_pkg::INS_RD_STATUS;

  assign cmdReady = state_q == H_IDLE;
  assign bus.ioStrobe = strobe_q;
  assign bus.ioInstr = instr_q;
  assign bus.ioFlag = flag_q;
  assign bus.hostData = data_q;
  assign bus.ioReset = rst_q;
  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign cmdRefused = refused_q;
  assign intPending = bus.intReq;

  // One instruction in flight; the answer comes back with the ack.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= H_IDLE;
      strobe_q <= 1'b0;
      instr_q <= 3'h0;
      flag_q <= 2'h0;
      data_q <= 16'h0000;
      rst_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspData_q <= 16'h0000;
      refused_q <= 1'b0;
    end else begin
      strobe_q <= take && !refuse;
      refused_q <= take && refuse;
      rspValid_q <= 1'b0;
      rst_q <= busResetReq;
      unique case (state_q)
        H_IDLE: begin
          if (take && !refuse) begin
            instr_q <= cmdInstr;
            flag_q <= cmdFlag;
            data_q <= cmdData;
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (bus.ioAck) begin
            rspValid_q <= 1'b1;
            rspData_q <= bus.devData;
            state_q <= H_IDLE;
          end
        end
        // The two unused codes fall back to idle.
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // A new drive selection or a kick demands a fresh status check.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readyOk_q <= 1'b0;
      checked_q <= 1'b0;
    end else if (state_q == H_WAIT && bus.ioAck && isStatus) begin
      readyOk_q <= bus.devData[dcr_pkg::ST_READY]; // RQ15
      checked_q <= 1'b1; // RQ16
    end else if (take && !refuse &&
      (kicks || cmdInstr == dcr_pkg::INS_LD_DADDR)) begin
      readyOk_q <= cmdInstr == dcr_pkg::INS_LD_DADDR ? 1'b0 : readyOk_q;
      checked_q <= 1'b0; // RQ16
    end
  end
endmodule
`default_nettype wire

// ### dcr_bus_props.sv
`timescale 1ns/1ps
`default_nettype none
// Bus-level checks between the CPU end and the disc controller end.
module dcr_bus_props (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Host to device.
  input wire logic ioStrobe,
  input wire logic [2:0] ioInstr,
  input wire logic [1:0] ioFlag,
  input wire logic [15:0] hostData,
  input wire logic ioReset,
  // Device to host.
  input wire logic [15:0] devData,
  input wire logic ioAck,
  input wire logic intReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic [15:0] macWord_q;
  logic macFresh_q;
  logic afterClear_q;
  // Decoded strobes of the instructions that the checks look at.
  wire logic isLdMac = ioStrobe && ioInstr == dcr_pkg::INS_LD_MAC;
  wire logic isKick = ioStrobe && ioFlag[0];
  // Remember the last loaded address and whether a clear came last.
  // A kick may start a transfer that moves the address, so it ends the
  // address comparison; a load during a running transfer is misjudged.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      macWord_q <= 16'h0000;
      macFresh_q <= 1'b0;
      afterClear_q <= 1'b1;
    end else begin
      if (isLdMac) begin
        macWord_q <= hostData;
      end
      if (isLdMac) begin
        macFresh_q <= !isKick;
      end else if (isKick || ioReset) begin
        macFresh_q <= 1'b0;
      end
      if (ioReset) begin
        afterClear_q <= 1'b1;
      end else if (ioStrobe) begin
        afterClear_q <= ioFlag == dcr_pkg::FC_CLEAR;
      end
    end
  end
  sequence s_rdStatus;
    ioStrobe && ioInstr == dcr_pkg::INS_RD_STATUS;
  endsequence
  sequence s_rdMac;
    ioStrobe && ioInstr == dcr_pkg::INS_RD_MAC;
  endsequence
  sequence s_clear;
    ioStrobe && ioFlag == dcr_pkg::FC_CLEAR;
  endsequence
  property p_ackAfterStrobe;
    ioStrobe |=> ioAck;
  endproperty
  property p_ackCause;
    ioAck |-> $past(ioStrobe);
  endproperty
  property p_rdMacBit0;
    s_rdMac |=> !devData[dcr_pkg::MAC_MAP];
  endproperty
  property p_statusGap;
    s_rdStatus |=> devData[10] == 1'b0;
  endproperty
  property p_clearFlags;
    s_rdStatus and afterClear_q |=>
      !devData[dcr_pkg::ST_DONE] && !devData[dcr_pkg::ST_BUSY];
  endproperty
  property p_clearInt;
    s_clear |-> ##[1:3] !intReq;
  endproperty
  property p_macRead;
    s_rdMac and macFresh_q |=> devData == {1'b0, macWord_q[14:0]};
  endproperty
  property p_devHold;
    $changed(devData) |-> ioAck;
  endproperty
  a_ackAfterStrobe: assert property (p_ackAfterStrobe) else $error("no ack");
  a_ackCause: assert property (p_ackCause) else $error("stray ack");
  a_rdMacBit0: assert property (p_rdMacBit0) else $error("map bit read");
  a_statusGap: assert property (p_statusGap) else $error("gap bit set");
  a_clearFlags: assert property (p_clearFlags) else $error("flags kept");
  a_clearInt: assert property (p_clearInt) else $error("int kept");
  a_macRead: assert property (p_macRead) else $error("address lost");
  a_devHold: assert property (p_devHold) else $error("data moved");
endmodule
`default_nettype wire

// ### disc_controller_host_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module disc_controller_host_regs_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cmdValid = 1'b0;
  logic [2:0] cmdInstr = 3'h0;
  logic [1:0] cmdFlag = 2'h0;
  logic [15:0] cmdData = 16'h0000;
  logic busResetReq = 1'b0;
  logic [3:0] driveReady = 4'hf;
  logic [3:0] driveUnsafe = 4'h0;
  logic [3:0] seekEnd = 4'h0;
  logic subsysOwned = 1'b1;
  logic sectorDone = 1'b0;
  logic [4:0] engErr = 5'h00;
  logic wrWordTaken = 1'b0;
  logic engValid = 1'b0;
  logic [15:0] engWord = 16'h0000;
  logic chanReady = 1'b0;
  logic cmdReady, rspValid, cmdRefused, intPending, opGo, xferHalt;
  logic engReady, chanValid, refused;
  logic [15:0] rspData, chanWord, chanAddr, rsp, goWord;
  logic [1:0] opCode, opDrive;
  logic [8:0] opCyl;
  logic [2:0] surfSel;
  logic [4:0] sectSel;
  int mismatches = 0;
  int total_checks = 0;
  int pushed = 0;
  int popped = 0;
  int halts = 0;
  int n;
  dcr_bus_if busLink();
  dcr_host i_dcr_host (.ref_clk(ref_clk), .rst(rst), .bus(busLink),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdInstr(cmdInstr),
    .cmdFlag(cmdFlag), .cmdData(cmdData), .busResetReq(busResetReq),
    .rspValid(rspValid), .rspData(rspData), .cmdRefused(cmdRefused),
    .intPending(intPending));
  dcr_device i_dcr_device (.ref_clk(ref_clk), .rst(rst), .bus(busLink),
    .driveReady(driveReady), .driveUnsafe(driveUnsafe), .seekEnd(seekEnd),
    .subsysOwned(subsysOwned), .opGo(opGo), .opCode(opCode), .opCyl(opCyl),
    .opDrive(opDrive), .xferHalt(xferHalt), .surfSel(surfSel),
    .sectSel(sectSel), .sectorDone(sectorDone), .engErr(engErr),
    .wrWordTaken(wrWordTaken), .engValid(engValid), .engWord(engWord),
    .engReady(engReady), .chanValid(chanValid), .chanWord(chanWord),
    .chanAddr(chanAddr), .chanReady(chanReady));
  dcr_bus_props i_dcr_bus_props (.ref_clk(ref_clk), .rst(rst),
    .ioStrobe(busLink.ioStrobe), .ioInstr(busLink.ioInstr),
    .ioFlag(busLink.ioFlag), .hostData(busLink.hostData),
    .ioReset(busLink.ioReset), .devData(busLink.devData),
    .ioAck(busLink.ioAck), .intReq(busLink.intReq));
  // A 200 MHz clock.
  always #2.5 ref_clk = ~ref_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction through the host end; the answer is kept in rsp.
  task automatic cmd(input logic [2:0] ins, input logic [1:0] fl,
      input logic [15:0] d);
    int k;
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdInstr <= ins;
    cmdFlag <= fl;
    cmdData <= d;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    for (k = 0; k < 10; k++) begin
      @(negedge ref_clk);
      if (rspValid === 1'b1 || cmdRefused === 1'b1) break;
    end
    rsp = rspData;
    refused = cmdRefused;
    // Return on a rising edge so that later stimulus is driven there.
    @(posedge ref_clk);
    if (k == 10) begin
      mismatches++;
      summarize();
    end
  endtask
  // Launches and channel words are recorded off the rising edge.
  always @(negedge ref_clk) begin
    if (opGo === 1'b1) begin
      goWord = {opCode, opDrive, 3'h0, opCyl};
    end
    if (engValid === 1'b1 && engReady === 1'b1) begin
      pushed++;
    end
    if (xferHalt === 1'b1) begin
      halts++;
    end
    if (chanValid === 1'b1 && chanReady === 1'b1) begin
      check(chanWord, 16'h0a00 + 16'(popped));
      popped++;
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0240);
    subsysOwned <= 1'b0;
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0040);
    subsysOwned <= 1'b1;
    cmd(dcr_pkg::INS_LD_MAC, dcr_pkg::FC_NONE, 16'h8123);
    cmd(dcr_pkg::INS_RD_MAC, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0123);
    cmd(dcr_pkg::INS_LD_DADDR, dcr_pkg::FC_START, 16'h0);
    check({15'h0, refused}, 16'h0001);
    // Seek on drive 1 with a pulse: done cleared, busy untouched.
    cmd(dcr_pkg::INS_LD_DADDR, dcr_pkg::FC_NONE, 16'h4000);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    cmd(dcr_pkg::INS_LD_CMD, dcr_pkg::FC_PULSE, 16'h25a5);
    driveReady <= 4'hd;
    check(goWord, {dcr_pkg::OP_SEEK, 2'h1, 3'h0, 9'h1a5});
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0200);
    @(posedge ref_clk);
    seekEnd <= 4'h2;
    driveReady <= 4'hf;
    @(posedge ref_clk);
    seekEnd <= 4'h0;
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h2240);
    check({15'h0, intPending}, 16'h0001);
    // The clear flag acts only after the status word has been moved.
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_CLEAR, 16'h0);
    check(rsp, 16'h2240);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0240);
    check({15'h0, intPending}, 16'h0000);
    // One sector read from the last sector of surface 0.
    cmd(dcr_pkg::INS_LD_DADDR, dcr_pkg::FC_NONE, 16'h017f);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    cmd(dcr_pkg::INS_LD_MAC, dcr_pkg::FC_NONE, 16'h7ffe);
    cmd(dcr_pkg::INS_LD_CMD, dcr_pkg::FC_START, 16'h8000);
    check(goWord, {dcr_pkg::OP_READ, 2'h0, 3'h0, 9'h000});
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0340);
    // Fill the buffer with the channel stalled until it refuses.
    @(posedge ref_clk);
    engValid <= 1'b1;
    engWord <= 16'h0a00;
    for (n = 0; n < 40; n++) begin
      @(negedge ref_clk);
      if (engReady !== 1'b1) break;
      @(posedge ref_clk);
      engWord <= 16'h0a00 + 16'(pushed);
    end
    @(posedge ref_clk);
    engValid <= 1'b0;
    check(16'(pushed), 16'(dcr_pkg::FIFO_DEPTH));
    chanReady <= 1'b1;
    for (n = 0; n < 40 && popped < pushed; n++) begin
      @(negedge ref_clk);
    end
    @(negedge ref_clk);
    check({15'h0, chanValid}, 16'h0000);
    check(chanAddr, 16'h801e);
    @(posedge ref_clk);
    sectorDone <= 1'b1;
    @(posedge ref_clk);
    sectorDone <= 1'b0;
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h8240);
    check({8'h0, surfSel, sectSel}, 16'h0020);
    check({15'h0, intPending}, 16'h0001);
    cmd(dcr_pkg::INS_RD_MAC, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h001e);
    // A pulse from the drive leaves the unsafe flag set until cleared.
    @(posedge ref_clk);
    driveUnsafe <= 4'h1;
    @(posedge ref_clk);
    driveUnsafe <= 4'h0;
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h82c1);
    // A bus reset behaves like the clear flag command.
    @(posedge ref_clk);
    busResetReq <= 1'b1;
    @(posedge ref_clk);
    busResetReq <= 1'b0;
    repeat (3) @(posedge ref_clk);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0240);
    check({15'h0, intPending}, 16'h0000);
    // Two-sector write: the address ends one past the last word taken.
    cmd(dcr_pkg::INS_LD_DADDR, dcr_pkg::FC_NONE, 16'h001e);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0240);
    cmd(dcr_pkg::INS_LD_MAC, dcr_pkg::FC_NONE, 16'h0100);
    cmd(dcr_pkg::INS_LD_CMD, dcr_pkg::FC_START, 16'h2200);
    check(goWord, {dcr_pkg::OP_WRITE, 2'h0, 3'h0, 9'h000});
    @(posedge ref_clk);
    wrWordTaken <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wrWordTaken <= 1'b0;
    sectorDone <= 1'b1;
    @(posedge ref_clk);
    sectorDone <= 1'b0;
    @(posedge ref_clk);
    sectorDone <= 1'b1;
    seekEnd <= 4'h4;
    @(posedge ref_clk);
    sectorDone <= 1'b0;
    seekEnd <= 4'h0;
    cmd(dcr_pkg::INS_RD_MAC, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0103);
    cmd(dcr_pkg::INS_RD_DADDR, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0030);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h9240);
    // Command bits clear done and the seek done of drive 2 only.
    cmd(dcr_pkg::INS_LD_CMD, dcr_pkg::FC_NONE, 16'h9000);
    cmd(dcr_pkg::INS_RD_STATUS, dcr_pkg::FC_NONE, 16'h0);
    check(rsp, 16'h0240);
    check(16'(halts), 16'h0002);
    summarize();
  end
endmodule
`default_nettype wire
